/* File: logic/sps_cfg.svh */
// Constants for the serial port select command link
//--------------------------------------------------------------
// Overview of operation
// - Link runs 19200 baud, 8 data bits, no parity, one stop bit.
// - No flow control; in sync use each valid received command byte is echoed unchanged, unless a later change replaces it before its frame starts.
// - Bytes 0x10 to 0x1F select host port 1 to 16 (byte minus 0x0F).
// - Byte 0x71 turns video off, selecting no host.
// - In sync use, a change of selected channel queues its command byte in one slot, replaced by a later change before sending; power use sends nothing.
// - A received command byte switches this unit, so masters drive followers.
// - Remote and follower switching only in follow mode; all units same baud.
// - Cascade hosts addressed by two digits at the first level only; second level digits stay zero.
// - Auxiliary port serves either power switch units or sync, one at a time.
//--------------------------------------------------------------
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH
`define SPS_CLK_HZ 50000000
`define SPS_BAUD 19200
`define SPS_BIT_CYC (`SPS_CLK_HZ / `SPS_BAUD)
`define SPS_DATA_BITS 8
`define SPS_CODE_LO 8'h10
`define SPS_CODE_HI 8'h1F
`define SPS_CODE_OFF 8'h71
`define SPS_PORT_BASE 8'h0F
`define SPS_PORT_NONE 5'h00
`define SPS_LINE_IDLE 1'b1
`endif

/* File: logic/sps_pkg.sv */
// Types for the serial port select command link
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_ST_IDLE = 2'b00,
    SPS_ST_START = 2'b01,
    SPS_ST_DATA = 2'b10,
    SPS_ST_STOP = 2'b11
  } sps_state_t;
  // Aux port use, only one at a time
  typedef enum logic {
    SPS_USE_POWER = 1'b0,
    SPS_USE_SYNC = 1'b1
  } sps_use_t;
  // Selection shown to the switch core
  typedef struct packed {
    logic video_on;
    logic [4:0] port;
  } sps_sel_t;
  // Two-level cascade address, two decimal digits per level
  typedef struct packed {
    logic [3:0] l1_tens;
    logic [3:0] l1_ones;
    logic [3:0] l2_tens;
    logic [3:0] l2_ones;
    logic two_level;
  } sps_casc_t;
endpackage : sps_pkg

/* File: logic/sps_link.sv */
// Serial port select command interpreter with UART
`timescale 1ns/1ps
`include "sps_cfg.svh"
module sps_link (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration
  input wire sps_pkg::sps_use_t aux_use,
  // Local channel change request from the switch core
  input wire logic loc_req,
  input wire logic [7:0] loc_code,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  // Selection, cascade address and transmit busy flag
  output sps_pkg::sps_sel_t sel,
  output sps_pkg::sps_casc_t casc,
  output logic tx_busy
);
  import sps_pkg::*;

  localparam int BITC = `SPS_BIT_CYC;
  localparam int HALFC = `SPS_BIT_CYC / 2;

  // Valid command check
  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c >= `SPS_CODE_LO && c <= `SPS_CODE_HI) || c == `SPS_CODE_OFF;
  endfunction : code_ok

  // Port number of a code, zero for video off
  function automatic logic [4:0] code_port(input logic [7:0] c);
    logic [7:0] p;
    p = c - `SPS_PORT_BASE;
    code_port = (c == `SPS_CODE_OFF) ? `SPS_PORT_NONE : p[4:0];
  endfunction : code_port

  // Binary port to two decimal digits
  function automatic logic [7:0] to_bcd(input logic [4:0] p);
    logic [4:0] ones;
    ones = (p >= 5'd10) ? p - 5'd10 : p;
    to_bcd = {(p >= 5'd10) ? 4'h1 : 4'h0, ones[3:0]};
  endfunction : to_bcd

  //------------------------------------------------------------
  // Receiver
  //------------------------------------------------------------
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, rx_lvl_d;
  sps_state_t rs_q, rs_d;
  logic [15:0] rc_q, rc_d;
  logic [2:0] rb_q, rb_d;
  logic [7:0] rsh_q, rsh_d;
  logic rx_vld_q, rx_vld_d;

  // Pin synchroniser; a change counts when stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_s1_q <= `SPS_LINE_IDLE;
      rx_s2_q <= `SPS_LINE_IDLE;
      rx_s3_q <= `SPS_LINE_IDLE;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // 8N1 frame receive, sampling mid bit
  always_comb begin
    rx_lvl_d = (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_lvl_q;
    rs_d = rs_q;
    rc_d = rc_q;
    rb_d = rb_q;
    rsh_d = rsh_q;
    rx_vld_d = 1'b0;
    case (rs_q)
      SPS_ST_IDLE: begin
        rc_d = 16'h0000;
        if (!rx_lvl_q) rs_d = SPS_ST_START;
      end
      SPS_ST_START: begin
        if (rc_q == 16'(HALFC - 1)) begin
          rc_d = 16'h0000;
          rb_d = 3'h0;
          rs_d = rx_lvl_q ? SPS_ST_IDLE : SPS_ST_DATA; // Glitch rejected
        end else rc_d = rc_q + 16'h0001;
      end
      SPS_ST_DATA: begin
        if (rc_q == 16'(BITC - 1)) begin
          rc_d = 16'h0000;
          rsh_d = {rx_lvl_q, rsh_q[7:1]}; // LSB first
          rb_d = rb_q + 3'h1;
          if (rb_q == 3'(`SPS_DATA_BITS - 1)) rs_d = SPS_ST_STOP;
        end else rc_d = rc_q + 16'h0001;
      end
      SPS_ST_STOP: begin
        if (rc_q == 16'(BITC - 1)) begin
          rs_d = SPS_ST_IDLE;
          rx_vld_d = rx_lvl_q; // Framing error drops the byte
        end else rc_d = rc_q + 16'h0001;
      end
      default: rs_d = SPS_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_lvl_q <= `SPS_LINE_IDLE;
      rs_q <= SPS_ST_IDLE;
      rc_q <= 16'h0000;
      rb_q <= 3'h0;
      rsh_q <= 8'h00;
      rx_vld_q <= 1'b0;
    end else begin
      rx_lvl_q <= rx_lvl_d;
      rs_q <= rs_d;
      rc_q <= rc_d;
      rb_q <= rb_d;
      rsh_q <= rsh_d;
      rx_vld_q <= rx_vld_d;
    end
  end

  //------------------------------------------------------------
  // Command decode, selection and transmit request
  //------------------------------------------------------------
  sps_sel_t sel_q, sel_d;
  sps_casc_t casc_q, casc_d;
  logic pend_q, pend_d;
  logic [7:0] pcode_q, pcode_d;
  logic tx_go;
  logic sync_on;
  logic rx_take, loc_take;
  logic [7:0] cmd;
  logic [4:0] np;
  logic [7:0] bcd;

  assign sync_on = (aux_use == SPS_USE_SYNC); // Power use blocks sync traffic

  always_comb begin
    sel_d = sel_q;
    casc_d = casc_q;
    pend_d = pend_q;
    pcode_d = pcode_q;
    rx_take = rx_vld_q && sync_on && code_ok(rsh_q); // Follow mode only, bad codes dropped
    loc_take = loc_req && code_ok(loc_code);
    cmd = rx_take ? rsh_q : loc_code;
    np = code_port(cmd);
    bcd = to_bcd(np);
    if (tx_go || !sync_on) pend_d = 1'b0; // Power use drops any queued frame
    if (rx_take || loc_take) begin
      sel_d.video_on = (cmd != `SPS_CODE_OFF);
      sel_d.port = np;
      casc_d.l1_tens = bcd[7:4];
      casc_d.l1_ones = bcd[3:0];
      casc_d.l2_tens = 4'h0;
      casc_d.l2_ones = 4'h0;
      casc_d.two_level = 1'b0;
      // Echo a received code; send local changes for followers
      if (sync_on && (rx_take || sel_d != sel_q)) begin
        pend_d = 1'b1;
        pcode_d = cmd;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_q <= '0;
      casc_q <= '0;
      pend_q <= 1'b0;
      pcode_q <= 8'h00;
    end else begin
      sel_q <= sel_d;
      casc_q <= casc_d;
      pend_q <= pend_d;
      pcode_q <= pcode_d;
    end
  end

  //------------------------------------------------------------
  // Transmitter, 8N1, no handshake lines
  //------------------------------------------------------------
  sps_state_t ts_q, ts_d;
  logic [15:0] tc_q, tc_d;
  logic [2:0] tb_q, tb_d;
  logic [7:0] tsh_q, tsh_d;
  logic txd_q, txd_d;
  logic busy_q, busy_d;

  assign tx_go = (ts_q == SPS_ST_IDLE) && pend_q && sync_on; // Silent in power use

  always_comb begin
    ts_d = ts_q;
    tc_d = tc_q;
    tb_d = tb_q;
    tsh_d = tsh_q;
    txd_d = txd_q;
    case (ts_q)
      SPS_ST_IDLE: begin
        txd_d = `SPS_LINE_IDLE;
        if (tx_go) begin
          tsh_d = pcode_q;
          tc_d = 16'h0000;
          txd_d = 1'b0; // Start bit
          ts_d = SPS_ST_START;
        end
      end
      SPS_ST_START: begin
        if (tc_q == 16'(BITC - 1)) begin
          tc_d = 16'h0000;
          tb_d = 3'h0;
          txd_d = tsh_q[0];
          ts_d = SPS_ST_DATA;
        end else tc_d = tc_q + 16'h0001;
      end
      SPS_ST_DATA: begin
        if (tc_q == 16'(BITC - 1)) begin
          tc_d = 16'h0000;
          tb_d = tb_q + 3'h1;
          tsh_d = {1'b0, tsh_q[7:1]};
          if (tb_q == 3'(`SPS_DATA_BITS - 1)) begin
            txd_d = `SPS_LINE_IDLE; // Stop bit
            ts_d = SPS_ST_STOP;
          end else txd_d = tsh_q[1];
        end else tc_d = tc_q + 16'h0001;
      end
      SPS_ST_STOP: begin
        if (tc_q == 16'(BITC - 1)) ts_d = SPS_ST_IDLE;
        else tc_d = tc_q + 16'h0001;
      end
      default: ts_d = SPS_ST_IDLE;
    endcase
    busy_d = (ts_d != SPS_ST_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ts_q <= SPS_ST_IDLE;
      tc_q <= 16'h0000;
      tb_q <= 3'h0;
      tsh_q <= 8'h00;
      txd_q <= `SPS_LINE_IDLE;
      busy_q <= 1'b0;
    end else begin
      ts_q <= ts_d;
      tc_q <= tc_d;
      tb_q <= tb_d;
      tsh_q <= tsh_d;
      txd_q <= txd_d;
      busy_q <= busy_d;
    end
  end

  // Outputs straight from flip-flops
  assign txd = txd_q;
  assign sel = sel_q;
  assign casc = casc_q;
  assign tx_busy = busy_q;
endmodule : sps_link

/* File: verif/sps_link_monitor.sv */
// Assertion checker for the serial port select link
`timescale 1ns/1ps
`include "sps_cfg.svh"
module sps_link_monitor (
  // Link ports
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sps_pkg::sps_use_t aux_use,
  input wire logic loc_req,
  input wire logic [7:0] loc_code,
  input wire logic rxd,
  input wire logic txd,
  input wire sps_pkg::sps_sel_t sel,
  input wire sps_pkg::sps_casc_t casc,
  input wire logic tx_busy
);
  import sps_pkg::*;
  logic txd_q;
  logic [15:0] run_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Count how long the previous txd level lasted
  always_ff @(posedge core_clk) begin
    txd_q <= txd;
    run_q <= (txd != txd_q) ? 16'h0001 : run_q + 16'h0001;
  end
  sequence s_tx_start; !txd && tx_busy; endsequence
  property p_bits; tx_busy && $past(tx_busy) && txd != txd_q |-> run_q % `SPS_BIT_CYC == 0; endproperty
  a_bits: assert property (p_bits) else $error("txd bit length");
  property p_start; !$stable(sel) && aux_use == SPS_USE_SYNC && !tx_busy |=> s_tx_start; endproperty
  a_start: assert property (p_start) else $error("no frame on change");
  property p_loc; loc_req && loc_code inside {[8'h10:8'h1F]} |=> sel == {1'b1, 5'($past(loc_code) - 8'h0F)}; endproperty
  a_loc: assert property (p_loc) else $error("port select");
  property p_off; loc_req && loc_code == 8'h71 |=> sel == 6'h00; endproperty
  a_off: assert property (p_off) else $error("video off");
  property p_bad; loc_req && !(loc_code inside {[8'h10:8'h1F], 8'h71}) |=> $stable(sel); endproperty
  a_bad: assert property (p_bad) else $error("bad code acted on");
  property p_casc; casc == {4'(sel.port / 10), 4'(sel.port % 10), 9'h000}; endproperty
  a_casc: assert property (p_casc) else $error("cascade digits");
  property p_power; aux_use == SPS_USE_POWER && !tx_busy |=> txd && !tx_busy; endproperty
  a_power: assert property (p_power) else $error("sent in power use");
  property p_rng; (sel.port inside {[5'h01:5'h10]}) == sel.video_on; endproperty
  a_rng: assert property (p_rng) else $error("port range");
endmodule : sps_link_monitor
bind sps_link sps_link_monitor i_sps_link_monitor (.core_clk(core_clk), .rst_n(rst_n), .aux_use(aux_use),
  .loc_req(loc_req), .loc_code(loc_code), .rxd(rxd), .txd(txd), .sel(sel), .casc(casc), .tx_busy(tx_busy));

/* File: verif/sps_host_model.sv */
// Remote serial controller model: sends command bytes, collects what comes back
`timescale 1ns/1ps
`include "sps_cfg.svh"
module sps_host_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic rxd,
  input wire logic txd
);
  logic [7:0] got_q[$];
  logic [7:0] b;
  initial rxd = `SPS_LINE_IDLE;
  // One frame at the shared baud, LSB first, idle high after
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk);
      rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i - 1];
      repeat (`SPS_BIT_CYC - 1) @(negedge core_clk);
    end
  endtask : send
  // Collect frames from txd; never sent back, so no switching loop
  always begin
    @(negedge txd);
    repeat (`SPS_BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (`SPS_BIT_CYC) @(posedge core_clk);
      b[i] = txd;
    end
    repeat (`SPS_BIT_CYC) @(posedge core_clk);
    if (txd) got_q.push_back(b);
  end
endmodule : sps_host_model

/* File: verif/sps_link_test.sv */
// Self-checking bench for the serial port select link
`timescale 1ns/1ps
module sps_link_test;
  import sps_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  sps_use_t aux_use = SPS_USE_SYNC;
  logic loc_req = 1'b0;
  logic [7:0] loc_code = 8'h00;
  logic rxd;
  logic txd;
  sps_sel_t sel;
  sps_casc_t casc;
  logic tx_busy;
  logic [7:0] exp[3];
  int bad_count = 0;
  int compares = 0;
  always #10 core_clk = ~core_clk;
  sps_link i_sps_link (.core_clk(core_clk), .rst_n(rst_n), .aux_use(aux_use), .loc_req(loc_req),
    .loc_code(loc_code), .rxd(rxd), .txd(txd), .sel(sel), .casc(casc), .tx_busy(tx_busy));
  sps_host_model i_sps_host_model (.core_clk(core_clk), .rxd(rxd), .txd(txd));
  // Compare selection and cascade digits for a port
  task automatic chk_sel(input logic [4:0] p);
    compares++;
    if (sel !== {p != 5'h00, p} || casc !== {4'(p / 10), 4'(p % 10), 9'h000}) begin
      bad_count++;
      $display("wrong value at %0t: sel %h casc %h", $time, sel, casc);
    end
  endtask : chk_sel
  // Compare one byte
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: byte %h not %h", $time, g, e);
    end
  endtask : chk_byte
  // One-cycle local request, then let the result land
  task automatic local_req(input logic [7:0] c);
    @(negedge core_clk);
    loc_req = 1'b1;
    loc_code = c;
    @(negedge core_clk);
    loc_req = 1'b0;
    @(negedge core_clk);
  endtask : local_req
  task automatic t_reset();
    chk_sel(5'h00);
    chk_byte({7'h00, txd}, 8'h01);
    $display("reset test done");
  endtask : t_reset
  task automatic t_local();
    local_req(8'h10);
    chk_sel(5'h01);
    local_req(8'h05);
    chk_sel(5'h01);
    $display("local test done");
  endtask : t_local
  // Back-to-back frames while the first frame is still going out
  task automatic t_remote();
    i_sps_host_model.send(8'h1F);
    chk_sel(5'h10);
    i_sps_host_model.send(8'h71);
    chk_sel(5'h00);
    i_sps_host_model.send(8'h20);
    chk_sel(5'h00);
    $display("remote test done");
  endtask : t_remote
  task automatic t_power();
    for (int i = 0; i < 30000 && tx_busy !== 1'b0; i++) @(negedge core_clk);
    aux_use = SPS_USE_POWER;
    local_req(8'h13);
    chk_sel(5'h04);
    local_req(8'h71);
    chk_sel(5'h00);
    repeat (200) @(negedge core_clk);
    exp = '{8'h10, 8'h1F, 8'h71};
    chk_byte(8'(i_sps_host_model.got_q.size()), 8'h03);
    foreach (exp[i]) chk_byte(i_sps_host_model.got_q[i], exp[i]);
    $display("power test done");
  endtask : t_power
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_reset();
    t_local();
    t_remote();
    t_power();
    print_verdict();
  end
  // Cut a hang short well past the expected run
  initial begin
    #(100000 * 20);
    bad_count++;
    print_verdict();
  end
endmodule : sps_link_test
